// *** shared/bld_pkg.sv ***
// Constants, field layout and carrier types of the backlight driver register bank.
// Assumes one 125 MHz clock and register access over the two-wire serial target port.
//
// Overview of operation
// RULE1: Reserved bits and write-only registers read zero
// RULE2: Reset register bit0 resets device, self-clears
// RULE3: Chip enable rising reloads brightness bit0, pwm register
// RULE4: Enable bits: chip, strings one-three, default on
// RULE5: Brightness bit7 selects linear or exponential mapping
// RULE6: Brightness bit4 enables ramping, default off
// RULE7: Pwm bits7-6 pick 800k, 4M, 24M sampling
// RULE8: Pwm bits4-2 set hysteresis, 111 invalid
// RULE9: Pwm bits1-0 select input glitch filter
// RULE10: Boost bit6 zero shifts frequency down twelve percent
// RULE11: Upper threshold splits 500 kHz and 1 MHz
// RULE12: Lower threshold splits 250 and 500 kHz
// RULE13: Thresholds compare upper eight brightness code bits
// RULE14: Ceiling input forces code upper bits to ceiling
// RULE15: Low code register holds three code LSBs
// RULE16: High code register holds eight code MSBs
// RULE17: Clear disable bit plus fault flag forces shutdown
// RULE18: Shutdown disable bits default to one
// RULE19: Brightness bits6-5 select brightness source
// RULE20: Brightness bits3-1 select doubling ramp step time
// RULE21: Boost bits select overvoltage and overcurrent limits
// RULE22: Short detect enable and boost frequency select
// RULE23: After fault shutdown, flag read permits re-enable
// RULE24: Host reconfigures only with strings off, chip on
// RULE25: Target address 0x36, each byte acknowledged
package bld_pkg;

  // =====================================================================
  // Serial target and register map
  localparam logic [6:0] TGT_ADDR     = 7'h36;
  localparam logic [7:0] ADR_REV      = 8'h00;
  localparam logic [7:0] ADR_SWRST    = 8'h01;
  localparam logic [7:0] ADR_EN       = 8'h10;
  localparam logic [7:0] ADR_BRT      = 8'h11;
  localparam logic [7:0] ADR_PWM      = 8'h12;
  localparam logic [7:0] ADR_BOOST    = 8'h13;
  localparam logic [7:0] ADR_AF_HI    = 8'h15;
  localparam logic [7:0] ADR_AF_LO    = 8'h16;
  localparam logic [7:0] ADR_CEIL     = 8'h17;
  localparam logic [7:0] ADR_CODE_LO  = 8'h18;
  localparam logic [7:0] ADR_CODE_HI  = 8'h19;
  localparam logic [7:0] ADR_FCTRL    = 8'h1e;
  localparam logic [7:0] ADR_FFLAG    = 8'h1f;

  // =====================================================================
  // Reset values and masks of the implemented bits
  localparam logic [7:0] EN_DEF       = 8'h0f;
  localparam logic [7:0] BRT_DEF      = 8'h61;
  localparam logic [7:0] PWM_DEF      = 8'h73;
  localparam logic [7:0] BOOST_DEF    = 8'h6f;
  localparam logic [7:0] THR_DEF      = 8'h00;
  localparam logic [7:0] CODE_LO_DEF  = 8'h07;
  localparam logic [7:0] CODE_HI_DEF  = 8'hff;
  localparam logic [7:0] FCTRL_DEF    = 8'h07;
  localparam logic [7:0] EN_MASK      = 8'h0f;
  localparam logic [7:0] BOOST_MASK   = 8'h7f;
  localparam logic [7:0] CODE_LO_MASK = 8'h07;
  localparam logic [7:0] FCTRL_MASK   = 8'h0f;
  localparam logic [7:0] FFLAG_MASK   = 8'h1f;
  localparam logic [7:0] REV_MASK     = 8'h0f;

  // =====================================================================
  // Field positions
  localparam int BRT_POL  = 0;
  localparam int BRT_RATE = 1;
  localparam int BRT_RAMP = 4;
  localparam int BRT_MODE = 5;
  localparam int BRT_MAP  = 7;
  localparam int PWM_FILT = 0;
  localparam int PWM_HYST = 2;
  localparam int PWM_POL  = 5;
  localparam int PWM_RATE = 6;
  localparam int BST_OCP  = 0;
  localparam int BST_OVP  = 2;
  localparam int BST_IND  = 4;
  localparam int BST_FSEL = 5;
  localparam int BST_SHFT = 6;
  localparam int FC_OVP   = 0;
  localparam int FC_OCP   = 1;
  localparam int FC_TSD   = 2;
  localparam int FC_SHORT = 3;

  // =====================================================================
  // Encodings
  localparam logic [1:0] SR_800K = 2'h0;
  localparam logic [1:0] SR_4M   = 2'h1;
  localparam logic [1:0] SR_24M  = 2'h2;
  localparam logic [1:0] AF_250K = 2'h0;
  localparam logic [1:0] AF_500K = 2'h1;
  localparam logic [1:0] AF_1M   = 2'h2;
  localparam logic [2:0] HYST_BAD = 3'h7;
  localparam logic [2:0] HYST_DEF = 3'h4;

  typedef enum logic [8:0] {
    S_IDLE  = 9'h001,
    S_ADDR  = 9'h002,
    S_ACK_A = 9'h004,
    S_REG   = 9'h008,
    S_ACK_R = 9'h010,
    S_WDATA = 9'h020,
    S_ACK_W = 9'h040,
    S_RDATA = 9'h080,
    S_RACK  = 9'h100
  } bld_fsm_t;

  typedef struct packed {
    logic        thermal_shutdown;
    logic        overcurrent_protection;
    logic        overvoltage_protection;
  } bld_fault_t;

  typedef struct packed {
    logic        chip_active;
    logic [2:0]  string_en;
    logic        shutdown;
    logic        map_exp;
    logic [1:0]  bright_mode;
    logic        ramp_en;
    logic [2:0]  ramp_rate;
    logic [1:0]  pwm_rate;
    logic        pwm_pol;
    logic [2:0]  pwm_hyst;
    logic [1:0]  pwm_filt;
    logic        freq_shift_en;
    logic        freq_1m;
    logic        ind_22uh;
    logic [1:0]  ovp_sel;
    logic [1:0]  ocp_sel;
    logic        short_det_en;
    logic [10:0] code;
    logic [1:0]  auto_freq;
  } bld_cfg_t;

  typedef struct packed {
    bld_fsm_t    fsm;
    logic [3:0]  cnt;
    logic [7:0]  shreg;
    logic [7:0]  ptr;
    logic        rw;
    logic        sda_drv;
    logic        scl_q;
    logic        sda_q;
    logic        swrst;
    logic        sd_latch;
    logic [7:0]  en;
    logic [7:0]  brt;
    logic [7:0]  pwm;
    logic [7:0]  boost;
    logic [7:0]  af_hi;
    logic [7:0]  af_lo;
    logic [7:0]  ceil;
    logic [7:0]  code_lo;
    logic [7:0]  code_hi;
    logic [7:0]  fctrl;
    bld_cfg_t    cfg;
  } bld_state_t;

endpackage : bld_pkg

// *** testbench/bld_i2c_host.sv ***
// Serial bus master model standing in for the host processor.
// Assumes the bench resolves sda from sda_m and the device open-drain pins.
`timescale 1ns/1ps
module bld_i2c_host
  import bld_pkg::*;
(
  input  wire logic sys_clk,
  output logic      scl,
  output logic      sda_m,
  input  wire logic sda_in
);
  logic [7:0] nacks;

  initial begin
    scl = 1'b1;
    sda_m = 1'b1;
    nacks = 8'h00;
  end

  // ==========================================================
  // Bit level, scl high for four sys_clk and low for five per bit
  task automatic half_bit();
    repeat (4) @(negedge sys_clk);
  endtask : half_bit

  task automatic start_cond();
    @(negedge sys_clk);
    sda_m = 1'b1;
    half_bit();
    scl = 1'b1;
    half_bit();
    sda_m = 1'b0;
    half_bit();
    scl = 1'b0;
  endtask : start_cond

  task automatic stop_cond();
    @(negedge sys_clk);
    sda_m = 1'b0;
    half_bit();
    scl = 1'b1;
    half_bit();
    sda_m = 1'b1;
    half_bit();
  endtask : stop_cond

  // Data moves one clk after the scl fall, never while scl is high
  task automatic bit_io(input logic b, output logic r);
    @(negedge sys_clk);
    sda_m = b;
    half_bit();
    scl = 1'b1;
    half_bit();
    r = sda_in;
    scl = 1'b0;
  endtask : bit_io

  // ==========================================================
  // Byte level, MSB first
  task automatic send_byte(input logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], r);
    end
    bit_io(1'b1, r);
    if (r !== 1'b0) begin
      nacks = nacks + 8'h01;
    end
  endtask : send_byte

  task automatic recv_byte(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, r);
      d[i] = r;
    end
    bit_io(last, r);
  endtask : recv_byte

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    start_cond();
    send_byte({TGT_ADDR, 1'b0});
    send_byte(a);
    send_byte(d);
    stop_cond();
  endtask : wr_reg

  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    start_cond();
    send_byte({TGT_ADDR, 1'b0});
    send_byte(a);
    start_cond();
    send_byte({TGT_ADDR, 1'b1});
    recv_byte(1'b1, d);
    stop_cond();
  endtask : rd_reg
endmodule : bld_i2c_host

// *** testbench/tb_top.sv ***
// Self-checking bench for the register bank, driven over the serial port.
// Assumes the host model above and the bld_pkg constants.
`timescale 1ns/1ps
module tb_top;
  import bld_pkg::*;
  logic       sys_clk, srst, scl, sda_m, sda_o, sda_oe_n, ceil_in, sda_w;
  bld_fault_t fault_in;
  logic [4:0] fault_flags;
  bld_cfg_t   cfg;
  logic [7:0] rv;
  int         err_count, checks;
  logic [7:0] da [13] = '{8'h00, 8'h01, 8'h10, 8'h11, 8'h12, 8'h13, 8'h14,
                          8'h15, 8'h16, 8'h17, 8'h18, 8'h19, 8'h1e};
  logic [7:0] de [13] = '{8'h09, 8'h00, 8'h0f, 8'h61, 8'h73, 8'h6f, 8'h00,
                          8'h00, 8'h00, 8'h00, 8'h07, 8'hff, 8'h07};

  // Pull-up: the wire is low only when someone pulls it
  assign sda_w = sda_m & (sda_oe_n | sda_o);

  bld_reg_bank #(.REV_CODE(4'h9)) u_bld_reg_bank (  // Arbitrary revision
    .sys_clk(sys_clk), .srst(srst), .scl_i(scl), .sda_i(sda_w), .sda_o(sda_o),
    .sda_oe_n(sda_oe_n), .brightness_ceiling_input(ceil_in),
    .fault_in(fault_in), .fault_flags(fault_flags), .cfg(cfg));
  bld_i2c_host u_bld_i2c_host (.sys_clk(sys_clk), .scl(scl), .sda_m(sda_m), .sda_in(sda_w));

  initial sys_clk = 1'b0;
  always #4 sys_clk = ~sys_clk;

  // ==========================================================
  // Helpers
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic w(input logic [7:0] a, input logic [7:0] d);
    u_bld_i2c_host.wr_reg(a, d);
  endtask : w

  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    u_bld_i2c_host.rd_reg(a, rv);
    check(rv, e);
  endtask : rc

  task automatic complete_run();
    $display("checks %0d err_count %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : complete_run

  initial begin
    #600us;
    err_count++;
    complete_run();
  end

  // ==========================================================
  // Test sequence
  initial begin
    err_count = 0;
    checks = 0;
    srst = 1'b1;
    ceil_in = 1'b0;
    fault_in = '0;
    fault_flags = 5'h15;
    repeat (20) @(negedge sys_clk);
    srst = 1'b0;
    repeat (3) @(negedge sys_clk);
    check(cfg.freq_shift_en, 1'h0);
    check(cfg.pwm_rate, SR_4M);
    check({cfg.pwm_hyst, cfg.pwm_filt}, {HYST_DEF, 2'h3});
    check({cfg.ramp_en, cfg.map_exp, cfg.bright_mode}, 4'h3);
    check({cfg.chip_active, cfg.string_en, cfg.code}, {4'hf, 11'h7ff});
    for (int i = 0; i < 13; i++) begin
      rc(da[i], de[i]);
    end
    w(ADR_EN, 8'h01);
    for (int m = 0; m < 4; m++) begin
      w(ADR_BRT, {m[0], m[1:0], ~m[0], m[1:0], m[0], 1'b1});
      check({cfg.map_exp, cfg.bright_mode, cfg.ramp_en}, {m[0], m[1:0], ~m[0]});
      check(cfg.ramp_rate, {m[1:0], m[0]});
    end
    for (int i = 0; i < 8; i++) begin
      w(ADR_PWM, {i[1:0], i[0], i[2:0], i[1:0]});
      check(cfg.pwm_rate, i[1] ? SR_24M : (i[0] ? SR_4M : SR_800K));
      check({cfg.pwm_hyst, cfg.pwm_filt}, {(i == 7) ? HYST_DEF : i[2:0], i[1:0]});
      check(cfg.pwm_pol, i[0]);
    end
    w(ADR_BOOST, 8'h90);
    rc(ADR_BOOST, 8'h10);
    check(cfg.ind_22uh, 1'h1);
    check({cfg.freq_shift_en, cfg.freq_1m, cfg.ovp_sel, cfg.ocp_sel}, 6'h20);
    w(ADR_CODE_LO, 8'hfa);
    rc(ADR_CODE_LO, 8'h02);
    w(ADR_FCTRL, 8'hf8);
    rc(ADR_FCTRL, 8'h08);
    check(cfg.short_det_en, 1'h1);
    w(ADR_CODE_HI, 8'h40);
    check(cfg.code, {8'h40, 3'h2});
    w(ADR_AF_HI, 8'h50);
    w(ADR_AF_LO, 8'h30);
    check(cfg.auto_freq, AF_500K);
    w(ADR_AF_LO, 8'h41);
    check(cfg.auto_freq, AF_250K);
    w(ADR_AF_HI, 8'h40);
    check(cfg.auto_freq, AF_1M);
    w(ADR_CEIL, 8'h22);
    ceil_in = 1'b1;
    repeat (3) @(negedge sys_clk);
    check(cfg.code, {8'h22, 3'h2});
    ceil_in = 1'b0;
    repeat (3) @(negedge sys_clk);
    check(cfg.code, {8'h40, 3'h2});
    w(ADR_SWRST, 8'h01);
    rc(ADR_SWRST, 8'h00);
    rc(ADR_CODE_HI, 8'hff);
    rc(ADR_AF_LO, 8'h00);
    w(ADR_EN, 8'h00);
    w(ADR_PWM, 8'h00);
    w(ADR_BRT, 8'h00);
    w(ADR_EN, 8'h01);
    rc(ADR_PWM, PWM_DEF);
    rc(ADR_BRT, 8'h01);
    for (int i = 0; i < 3; i++) begin
      w(ADR_FCTRL, 8'h07 ^ (8'h01 << i));
      fault_in = 3'(1 << i);
      repeat (4) @(negedge sys_clk);
      fault_in = '0;
      w(ADR_EN, 8'h01);
      check({cfg.shutdown, cfg.chip_active}, 2'h2);
      rc(ADR_FFLAG, 8'h15);
      repeat (3) @(negedge sys_clk);
      check({cfg.shutdown, cfg.chip_active}, 2'h1);
    end
    w(ADR_FCTRL, 8'h07);
    fault_in = 3'h7;
    repeat (4) @(negedge sys_clk);
    check(cfg.shutdown, 1'h0);
    fault_in = '0;
    u_bld_i2c_host.start_cond();
    u_bld_i2c_host.send_byte({7'h35, 1'b0});
    u_bld_i2c_host.stop_cond();
    check(u_bld_i2c_host.nacks, 8'h01);
    complete_run();
  end
endmodule : tb_top

// *** verilog/bld_reg_bank.sv ***
// Register bank of the three-string backlight driver with its serial target port.
// Assumes scl_i and sda_i already synchronous to sys_clk; the pad resolves sda.
`timescale 1ns/1ps
module bld_reg_bank
  import bld_pkg::*;
#(
  parameter logic [3:0] REV_CODE = 4'h1  // Arbitrary value
) (
  input  wire logic       sys_clk,
  input  wire logic       srst,
  input  wire logic       scl_i,
  input  wire logic       sda_i,
  output logic            sda_o,
  output logic            sda_oe_n,
  input  wire logic       brightness_ceiling_input,
  input  wire bld_fault_t fault_in,
  input  wire logic [4:0] fault_flags,
  output bld_cfg_t        cfg
);

  // =====================================================================
  // State
  bld_state_t st_ff;
  bld_state_t nxt_st;
  logic       scl_rise;
  logic       scl_fall;
  logic       start_cond;
  logic       stop_cond;
  logic       wr_en;
  logic [7:0] rd_byte;
  logic       rd_ld;
  logic       flag_read;
  logic       sd_set;
  logic       ceil_act;

  function automatic logic [7:0] rd_mux(input bld_state_t s, input logic [7:0] a,
                                        input logic [4:0] ff, input logic [3:0] rv);
    logic [7:0] r;
    r = 8'h00;
    unique case (a)
      ADR_REV:     r = {4'h0, rv} & REV_MASK;
      ADR_EN:      r = s.en & EN_MASK;
      ADR_BRT:     r = s.brt;
      ADR_PWM:     r = s.pwm;
      ADR_BOOST:   r = s.boost & BOOST_MASK;
      ADR_AF_HI:   r = s.af_hi;
      ADR_AF_LO:   r = s.af_lo;
      ADR_CEIL:    r = s.ceil;
      ADR_CODE_LO: r = s.code_lo & CODE_LO_MASK;
      ADR_CODE_HI: r = s.code_hi;
      ADR_FCTRL:   r = s.fctrl & FCTRL_MASK;
      ADR_FFLAG:   r = {3'h0, ff} & FFLAG_MASK;
      default:     r = 8'h00;  // RULE1
    endcase
    return r;
  endfunction : rd_mux

  assign scl_rise   = scl_i & ~st_ff.scl_q;
  assign scl_fall   = ~scl_i & st_ff.scl_q;
  assign start_cond = scl_i & st_ff.scl_q & st_ff.sda_q & ~sda_i;
  assign stop_cond  = scl_i & st_ff.scl_q & ~st_ff.sda_q & sda_i;
  assign sda_o      = 1'b0;
  assign sda_oe_n   = ~st_ff.sda_drv;
  assign cfg        = st_ff.cfg;

  // =====================================================================
  // Next state
  always_comb begin
    nxt_st       = st_ff;
    nxt_st.scl_q = scl_i;
    nxt_st.sda_q = sda_i;
    nxt_st.swrst = 1'b0;
    wr_en        = 1'b0;
    rd_ld        = 1'b0;
    rd_byte      = rd_mux(st_ff, st_ff.ptr, fault_flags, REV_CODE);
    if (stop_cond) begin
      nxt_st.fsm     = S_IDLE;
      nxt_st.sda_drv = 1'b0;
    end else if (start_cond) begin
      // Repeated start behaves as a plain start
      nxt_st.fsm     = S_ADDR;
      nxt_st.cnt     = 4'h0;
      nxt_st.sda_drv = 1'b0;
    end else if (scl_rise) begin
      unique case (st_ff.fsm)
        S_ADDR, S_REG, S_WDATA: begin
          nxt_st.shreg = {st_ff.shreg[6:0], sda_i};
          nxt_st.cnt   = st_ff.cnt + 4'h1;
        end
        S_RDATA: begin
          nxt_st.cnt = st_ff.cnt + 4'h1;
        end
        S_RACK: begin
          if (sda_i) begin
            nxt_st.fsm = S_IDLE;
          end
        end
        S_IDLE, S_ACK_A, S_ACK_R, S_ACK_W: begin
          nxt_st.fsm = st_ff.fsm;
        end
        default: begin
          nxt_st.fsm = S_IDLE;
        end
      endcase
    end else if (scl_fall) begin
      unique case (st_ff.fsm)
        S_ADDR: begin
          if (st_ff.cnt == 4'h8) begin
            if (st_ff.shreg[7:1] == TGT_ADDR) begin
              nxt_st.fsm     = S_ACK_A;
              nxt_st.sda_drv = 1'b1;  // RULE25
              nxt_st.rw      = st_ff.shreg[0];
            end else begin
              nxt_st.fsm = S_IDLE;
            end
          end
        end
        S_REG: begin
          if (st_ff.cnt == 4'h8) begin
            nxt_st.fsm     = S_ACK_R;
            nxt_st.sda_drv = 1'b1;  // RULE25
            nxt_st.ptr     = st_ff.shreg;
          end
        end
        S_WDATA: begin
          if (st_ff.cnt == 4'h8) begin
            nxt_st.fsm     = S_ACK_W;
            nxt_st.sda_drv = 1'b1;  // RULE25
            wr_en          = 1'b1;
          end
        end
        S_ACK_A: begin
          nxt_st.cnt = 4'h0;
          if (st_ff.rw) begin
            rd_ld = 1'b1;
          end else begin
            nxt_st.fsm     = S_REG;
            nxt_st.sda_drv = 1'b0;
          end
        end
        S_ACK_R, S_ACK_W: begin
          nxt_st.fsm     = S_WDATA;
          nxt_st.cnt     = 4'h0;
          nxt_st.sda_drv = 1'b0;
        end
        S_RDATA: begin
          if (st_ff.cnt == 4'h8) begin
            nxt_st.fsm     = S_RACK;
            nxt_st.sda_drv = 1'b0;
          end else begin
            nxt_st.shreg   = {st_ff.shreg[6:0], 1'b0};
            nxt_st.sda_drv = ~st_ff.shreg[6];
          end
        end
        S_RACK: begin
          nxt_st.cnt = 4'h0;
          rd_ld      = 1'b1;
        end
        S_IDLE: begin
          nxt_st.fsm = S_IDLE;
        end
        default: begin
          nxt_st.fsm = S_IDLE;
        end
      endcase
    end
    // Byte load for a read, pointer auto-increments
    if (rd_ld) begin
      nxt_st.fsm     = S_RDATA;
      nxt_st.shreg   = rd_byte;
      nxt_st.sda_drv = ~rd_byte[7];
      nxt_st.ptr     = st_ff.ptr + 8'h01;
    end
    flag_read = rd_ld && (st_ff.ptr == ADR_FFLAG);

    // =====================================================================
    // Register writes
    if (wr_en) begin
      nxt_st.ptr = st_ff.ptr + 8'h01;
      unique case (st_ff.ptr)
        ADR_SWRST:   nxt_st.swrst = st_ff.shreg[0];  // RULE2
        ADR_EN: begin
          nxt_st.en = st_ff.shreg & EN_MASK;  // RULE4
          if (st_ff.shreg[0] && !st_ff.en[0]) begin
            nxt_st.brt[BRT_POL] = BRT_DEF[BRT_POL];  // RULE3
            nxt_st.pwm          = PWM_DEF;           // RULE3
          end
        end
        ADR_BRT:     nxt_st.brt     = st_ff.shreg;
        ADR_PWM:     nxt_st.pwm     = st_ff.shreg;
        ADR_BOOST:   nxt_st.boost   = st_ff.shreg & BOOST_MASK;
        ADR_AF_HI:   nxt_st.af_hi   = st_ff.shreg;                 // RULE11
        ADR_AF_LO:   nxt_st.af_lo   = st_ff.shreg;                 // RULE12
        ADR_CEIL:    nxt_st.ceil    = st_ff.shreg;
        ADR_CODE_LO: nxt_st.code_lo = st_ff.shreg & CODE_LO_MASK;  // RULE15
        ADR_CODE_HI: nxt_st.code_hi = st_ff.shreg;                 // RULE16
        ADR_FCTRL:   nxt_st.fctrl   = st_ff.shreg & FCTRL_MASK;
        default:     nxt_st.ptr     = st_ff.ptr + 8'h01;
      endcase
    end

    // =====================================================================
    // Fault shutdown: latched until the flag register is read or a soft reset clears it
    sd_set = st_ff.en[0] &&
             ((fault_in.thermal_shutdown       && !st_ff.fctrl[FC_TSD]) ||
              (fault_in.overcurrent_protection && !st_ff.fctrl[FC_OCP]) ||
              (fault_in.overvoltage_protection && !st_ff.fctrl[FC_OVP]));  // RULE17
    if (sd_set) begin
      nxt_st.sd_latch = 1'b1;  // RULE17
    end else if (flag_read) begin
      nxt_st.sd_latch = 1'b0;  // RULE23
    end

    // Soft reset clears registers one cycle after the write; the serial port keeps going
    if (st_ff.swrst) begin
      nxt_st.en       = EN_DEF;     // RULE4
      nxt_st.brt      = BRT_DEF;    // RULE2
      nxt_st.pwm      = PWM_DEF;
      nxt_st.boost    = BOOST_DEF;
      nxt_st.af_hi    = THR_DEF;
      nxt_st.af_lo    = THR_DEF;
      nxt_st.ceil     = THR_DEF;
      nxt_st.code_lo  = CODE_LO_DEF;
      nxt_st.code_hi  = CODE_HI_DEF;
      nxt_st.fctrl    = FCTRL_DEF;  // RULE18
      nxt_st.sd_latch = 1'b0;
    end

    // =====================================================================
    // Decoded configuration, one cycle behind the registers
    ceil_act = ~(brightness_ceiling_input ^ st_ff.brt[BRT_POL]);
    nxt_st.cfg.chip_active  = st_ff.en[0] & ~st_ff.sd_latch;  // RULE23
    nxt_st.cfg.string_en    = st_ff.en[3:1];                  // RULE4
    nxt_st.cfg.shutdown     = st_ff.sd_latch;
    nxt_st.cfg.map_exp      = st_ff.brt[BRT_MAP];             // RULE5
    nxt_st.cfg.bright_mode  = st_ff.brt[BRT_MODE +: 2];       // RULE19
    nxt_st.cfg.ramp_en      = st_ff.brt[BRT_RAMP];            // RULE6
    nxt_st.cfg.ramp_rate    = st_ff.brt[BRT_RATE +: 3];       // RULE20
    nxt_st.cfg.pwm_rate     = st_ff.pwm[PWM_RATE + 1] ? SR_24M :
                              (st_ff.pwm[PWM_RATE] ? SR_4M : SR_800K);  // RULE7
    nxt_st.cfg.pwm_pol      = st_ff.pwm[PWM_POL];
    // Invalid hysteresis code falls back to the default
    nxt_st.cfg.pwm_hyst     = (st_ff.pwm[PWM_HYST +: 3] == HYST_BAD) ? HYST_DEF :
                              st_ff.pwm[PWM_HYST +: 3];       // RULE8
    nxt_st.cfg.pwm_filt     = st_ff.pwm[PWM_FILT +: 2];       // RULE9
    nxt_st.cfg.freq_shift_en = ~st_ff.boost[BST_SHFT];        // RULE10
    nxt_st.cfg.freq_1m      = st_ff.boost[BST_FSEL];          // RULE22
    nxt_st.cfg.ind_22uh     = st_ff.boost[BST_IND];
    nxt_st.cfg.ovp_sel      = st_ff.boost[BST_OVP +: 2];      // RULE21
    nxt_st.cfg.ocp_sel      = st_ff.boost[BST_OCP +: 2];      // RULE21
    nxt_st.cfg.short_det_en = st_ff.fctrl[FC_SHORT];          // RULE22
    nxt_st.cfg.code         = {ceil_act ? st_ff.ceil : st_ff.code_hi,
                               st_ff.code_lo[2:0]};           // RULE14
    if (nxt_st.cfg.code[10:3] >= st_ff.af_hi) begin
      nxt_st.cfg.auto_freq = AF_1M;    // RULE13
    end else if (nxt_st.cfg.code[10:3] >= st_ff.af_lo) begin
      nxt_st.cfg.auto_freq = AF_500K;  // RULE13
    end else begin
      nxt_st.cfg.auto_freq = AF_250K;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      st_ff          <= '0;
      st_ff.fsm      <= S_IDLE;
      st_ff.scl_q    <= 1'b1;
      st_ff.sda_q    <= 1'b1;
      st_ff.en       <= EN_DEF;
      st_ff.brt      <= BRT_DEF;
      st_ff.pwm      <= PWM_DEF;
      st_ff.boost    <= BOOST_DEF;
      st_ff.code_lo  <= CODE_LO_DEF;
      st_ff.code_hi  <= CODE_HI_DEF;
      st_ff.fctrl    <= FCTRL_DEF;
      st_ff.cfg.code <= 11'h7ff;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // =====================================================================
  // Assertions
  default clocking dck @(posedge sys_clk); endclocking
  default disable iff (srst);

  sequence swrst_written;
    wr_en && (st_ff.ptr == ADR_SWRST) && st_ff.shreg[0];
  endsequence

  sequence regs_defaulted;
    (st_ff.en == EN_DEF) && (st_ff.fctrl == FCTRL_DEF) && (st_ff.code_hi == CODE_HI_DEF);
  endsequence

  a_swrst_self_clear: assert property (swrst_written |=> st_ff.swrst ##1  // RULE2
                                       (!st_ff.swrst and regs_defaulted))
    else $error("soft reset did not restore defaults or self-clear");
  a_rsvd_read_zero: assert property (rd_ld && (st_ff.ptr == ADR_SWRST ||  // RULE1
                                     st_ff.ptr == ADR_CODE_LO) |=>
                                     st_ff.shreg[7:3] == 5'h00)
    else $error("reserved or write-only bits read non-zero");
  a_enable_reload: assert property (wr_en && st_ff.ptr == ADR_EN && st_ff.shreg[0] &&  // RULE3
                                    !st_ff.en[0] |=> st_ff.pwm == PWM_DEF &&
                                    st_ff.brt[BRT_POL])
    else $error("chip enable rise did not reload defaults");
  a_ceiling_force: assert property (ceil_act && !st_ff.swrst && !wr_en |=>  // RULE14
                                    st_ff.cfg.code[10:3] == $past(st_ff.ceil))
    else $error("ceiling not forced onto code");
  a_fault_shutdown: assert property (sd_set && !st_ff.swrst |=> st_ff.sd_latch ##1  // RULE17
                                     !st_ff.cfg.chip_active)
    else $error("fault with shutdown enabled did not disable chip");
  a_shutdown_hold: assert property (st_ff.sd_latch && !flag_read && !st_ff.swrst  // RULE23
                                    |=> st_ff.sd_latch)
    else $error("shutdown released without flag read");
  a_addr_ack: assert property (scl_fall && !start_cond && !stop_cond &&  // RULE25
                               st_ff.fsm == S_ADDR && st_ff.cnt == 4'h8 &&
                               st_ff.shreg[7:1] == TGT_ADDR |=> !sda_oe_n [*1] ##0
                               st_ff.fsm == S_ACK_A)
    else $error("own address not acknowledged");
  a_auto_freq: assert property (st_ff.cfg.auto_freq == AF_1M |->  // RULE13
                                st_ff.cfg.code[10:3] >= $past(st_ff.af_hi))
    else $error("auto frequency 1 MHz chosen below upper threshold");
  a_hyst_valid: assert property (st_ff.cfg.pwm_hyst != HYST_BAD)  // RULE8
    else $error("invalid hysteresis code passed on");
  a_mid_freq: assert property (st_ff.cfg.auto_freq == AF_500K |->  // RULE11
    st_ff.cfg.code[10:3] < $past(st_ff.af_hi) &&
    st_ff.cfg.code[10:3] >= $past(st_ff.af_lo))
    else $error("auto frequency 500 kHz outside its band");
  a_low_freq: assert property (!$past(srst) && st_ff.cfg.auto_freq == AF_250K |->  // RULE12
    st_ff.cfg.code[10:3] < $past(st_ff.af_lo))
    else $error("auto frequency 250 kHz above lower threshold");
  a_code_follow: assert property (!ceil_act |=>  // RULE16
    st_ff.cfg.code[10:3] == $past(st_ff.code_hi))
    else $error("code upper bits not from register");
  a_code_low: assert property (1'b1 |=>  // RULE15
    st_ff.cfg.code[2:0] == $past(st_ff.code_lo[2:0]))
    else $error("code lower bits not from register");
  a_shift_invert: assert property (1'b1 |=>  // RULE10
    st_ff.cfg.freq_shift_en != $past(st_ff.boost[BST_SHFT]))
    else $error("frequency shift not inverse of its bit");
  a_report_only: assert property (st_ff.fctrl[2:0] == 3'h7 && !st_ff.sd_latch |=>  // RULE18
    !st_ff.sd_latch)
    else $error("shutdown with all disables set");
  a_swrst_pulse: assert property (st_ff.swrst |=> !st_ff.swrst)  // RULE2
    else $error("soft reset bit stuck");
  a_rsvd_stored: assert property (st_ff.en[7:4] == 4'h0 && st_ff.fctrl[7:4] == 4'h0 &&  // RULE1
    st_ff.code_lo[7:3] == 5'h00)
    else $error("reserved bits hold ones");
  a_shut_blocks_en: assert property (st_ff.cfg.chip_active |->  // RULE23
    !$past(st_ff.sd_latch))
    else $error("chip active while shut down");
  a_strings_follow: assert property (1'b1 |=>  // RULE4
    st_ff.cfg.string_en == $past(st_ff.en[3:1]))
    else $error("string enables not passed on");
  a_filter_select: assert property (1'b1 |=>  // RULE9
    st_ff.cfg.pwm_filt == $past(st_ff.pwm[PWM_FILT +: 2]))
    else $error("glitch filter not passed on");
  a_ramp_select: assert property (1'b1 |=>  // RULE6
    st_ff.cfg.ramp_en == $past(st_ff.brt[BRT_RAMP]))
    else $error("ramp enable not passed on");
  a_map_select: assert property (1'b1 |=>  // RULE5
    st_ff.cfg.map_exp == $past(st_ff.brt[BRT_MAP]))
    else $error("mapping not passed on");
  a_mode_select: assert property (1'b1 |=>  // RULE19
    st_ff.cfg.bright_mode == $past(st_ff.brt[BRT_MODE +: 2]))
    else $error("brightness source not passed on");
  a_rate_select: assert property (1'b1 |=>  // RULE7
    st_ff.cfg.pwm_rate == ($past(st_ff.pwm[PWM_RATE + 1]) ? SR_24M :
    ($past(st_ff.pwm[PWM_RATE]) ? SR_4M : SR_800K)))
    else $error("sampling rate wrong");

endmodule : bld_reg_bank
